// ---- kwu_keypad_wake_unit.sv ----
// Keypad wake unit top: AHB-Lite registers, request latch, pull control
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module kwu_keypad_wake_unit
    import kwu_pkg::*;
#(
    parameter int NPINS = kwu_pkg::KWU_NUM_PINS
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic      [31:0]      hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    input  wire logic [NPINS-1:0] keypad_input_pins,
    input  wire logic [NPINS-1:0] port_direction,
    output logic      [NPINS-1:0] pin_force_input,
    output logic      [NPINS-1:0] pull_up_enable,
    output logic      [NPINS-1:0] pull_down_enable,
    input  wire logic             vector_fetch,
    input  wire logic             break_state,
    input  wire logic             break_clear_enable_in,
    output logic                  cpu_irq_request,
    output logic                  pending_flag
);
    import kwu_pkg::*;

    // ------------------------------------------------------------
    // Registers and internal signals
    // ------------------------------------------------------------
    logic [NPINS-1:0] pin_irq_enable_reg;
    logic [NPINS-1:0] pin_polarity_select_reg;
    logic             sensitivity_select_reg;
    logic             request_mask_reg;
    logic             break_clear_enable_reg;
    logic             latch_reg;
    logic [NPINS-1:0] pin_level;
    logic [NPINS-1:0] asserted;
    logic [NPINS-1:0] edge_seen;
    logic             any_asserted;
    logic             any_edge;
    logic             any_other_held;
    logic             set_event;
    logic             sw_ack;
    logic             ack_event;
    logic             clear_allowed;
    logic             ack_held_reg;
    logic             wr_pend_reg;
    logic [7:0]       wr_addr_reg;

    // ------------------------------------------------------------
    // Input conditioning
    // ------------------------------------------------------------
    // synchronise pins
    kwu_sync #(
        .WIDTH (NPINS)
    ) u_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in (keypad_input_pins),
        .sync_out (pin_level)
    );

    kwu_edge #(
        .WIDTH (NPINS)
    ) u_edge (
        .hclk                (hclk),
        .hresetn             (hresetn),
        .pin_level           (pin_level),
        .pin_polarity_select (pin_polarity_select_reg),
        .pin_irq_enable      (pin_irq_enable_reg),
        .asserted            (asserted),
        .edge_seen           (edge_seen)
    );

    // ------------------------------------------------------------
    // Pad control
    // ------------------------------------------------------------
    // enable forces input
    assign pin_force_input  = pin_irq_enable_reg;
    assign pull_up_enable   = pin_irq_enable_reg & ~pin_polarity_select_reg;
    assign pull_down_enable = pin_irq_enable_reg & pin_polarity_select_reg;

    // ------------------------------------------------------------
    // AHB-Lite slave: zero wait states, always OKAY
    // ------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp     = HRESP_OKAY[0];

    // Selected single transfer inside the page; anything above it is
    // refused, so a stray high address can neither read nor write here
    function automatic logic kwu_access_hit(
        input var logic        sel,
        input var logic [1:0]  trans,
        input var logic [31:0] addr
    );
        kwu_access_hit = sel && trans == HTRANS_NONSEQ && addr[31:8] == 24'h000000;
    endfunction : kwu_access_hit

    // Address phase capture for the following data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end
        else if (hready)
        begin
            wr_pend_reg <= kwu_access_hit(hsel, htrans, haddr) && hwrite;
            wr_addr_reg <= haddr[7:0];
        end
    end

    // Read data registered at the end of the address phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h00000000;
        else if (hready && kwu_access_hit(hsel, htrans, haddr) && !hwrite)
        begin
            hrdata <= 32'h00000000;
            case (haddr[7:0])
                KWU_STATUS_CONTROL_OFS:
                begin
                    hrdata[KWU_FLAG_BIT] <= latch_reg;
                    hrdata[KWU_ACK_BIT]  <= 1'b0;
                    hrdata[KWU_MASK_BIT] <= request_mask_reg;
                    hrdata[KWU_SENS_BIT] <= sensitivity_select_reg;
                end
                KWU_PIN_ENABLE_OFS:
                    hrdata[NPINS-1:0] <= pin_irq_enable_reg;
                KWU_PIN_POLARITY_OFS:
                    hrdata[NPINS-1:0] <= pin_polarity_select_reg;
                KWU_BREAK_CTRL_OFS:
                    hrdata[KWU_BREAK_CLEAR_BIT] <= break_clear_enable_reg;
                KWU_PIN_LEVEL_OFS:
                    // level visible only where direction is input
                    hrdata[NPINS-1:0] <= pin_level & ~port_direction;
                default:
                    hrdata <= 32'h00000000;
            endcase
        end
        else if (hready)
            hrdata <= 32'h00000000;
    end

    // per-pin enable and polarity, shared sensitivity and mask, break clear, reset values
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin_irq_enable_reg      <= KWU_PIN_RESET[NPINS-1:0];
            pin_polarity_select_reg <= KWU_PIN_RESET[NPINS-1:0];
            sensitivity_select_reg  <= KWU_SENS_RESET;
            request_mask_reg        <= KWU_MASK_RESET;
            break_clear_enable_reg  <= 1'b0;
        end
        else if (wr_pend_reg)
        begin
            case (wr_addr_reg)
                KWU_STATUS_CONTROL_OFS:
                begin
                    sensitivity_select_reg <= hwdata[KWU_SENS_BIT];
                    request_mask_reg       <= hwdata[KWU_MASK_BIT];
                end
                KWU_PIN_ENABLE_OFS:
                    pin_irq_enable_reg <= hwdata[NPINS-1:0];
                KWU_PIN_POLARITY_OFS:
                    pin_polarity_select_reg <= hwdata[NPINS-1:0];
                KWU_BREAK_CTRL_OFS:
                    break_clear_enable_reg <= hwdata[KWU_BREAK_CLEAR_BIT];
                default:
                    break_clear_enable_reg <= break_clear_enable_reg;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Request latch
    // ------------------------------------------------------------
    // software ack from a write of one
    assign sw_ack = wr_pend_reg && wr_addr_reg == KWU_STATUS_CONTROL_OFS && hwdata[KWU_ACK_BIT];

    // break protects status unless clear enabled; clear allowed
    assign clear_allowed = !break_state || break_clear_enable_reg || break_clear_enable_in;
    assign ack_event     = (sw_ack || vector_fetch) && clear_allowed;

    assign any_asserted = |asserted;
    assign any_edge     = |edge_seen;

    // another enabled pin already held blocks a new edge
    assign any_other_held = |(asserted & ~edge_seen);

    // set on assertion; level mode keeps request while asserted
    always_comb
    begin
        if (sensitivity_select_reg)
            set_event = any_asserted;
        else
            set_event = any_edge && !any_other_held;
    end

    // remember an acknowledge taken while a pin is still held
    // without it the level set would swallow the ack and the request
    // would hang after release. A new edge demands a fresh ack.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ack_held_reg <= 1'b0;
        else if (!sensitivity_select_reg || !latch_reg || any_edge)
            ack_held_reg <= 1'b0;
        else if (ack_event)
            ack_held_reg <= 1'b1;
    end

    // Set beats clear, so an edge in the ack cycle is kept
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            latch_reg <= 1'b0;
        else if (set_event)
            // fresh edge after ack latches; level holds until released
            latch_reg <= 1'b1;
        else if (ack_event || (ack_held_reg && clear_allowed))
            // immediate clear in edge mode, stored ack, stays cleared
            latch_reg <= 1'b0;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // mask gate; no clock gating so wake works in low power
    assign cpu_irq_request = latch_reg & ~request_mask_reg;
    assign pending_flag    = latch_reg;
endmodule : kwu_keypad_wake_unit
`default_nettype wire

// ---- kwu_pkg.sv ----
// Package with register map and field layout of the keypad wake unit
package kwu_pkg;
    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] KWU_STATUS_CONTROL_OFS = 8'h00;
    localparam logic [7:0] KWU_PIN_ENABLE_OFS     = 8'h04;
    localparam logic [7:0] KWU_PIN_POLARITY_OFS   = 8'h08;
    localparam logic [7:0] KWU_BREAK_CTRL_OFS     = 8'h0C;
    localparam logic [7:0] KWU_PIN_LEVEL_OFS      = 8'h10;
    // ------------------------------------------------------------
    // Status and control fields
    // ------------------------------------------------------------
    localparam int KWU_SENS_BIT = 0;
    localparam int KWU_MASK_BIT = 1;
    localparam int KWU_ACK_BIT  = 2;
    localparam int KWU_FLAG_BIT = 3;
    localparam int KWU_BREAK_CLEAR_BIT = 0;
    // ------------------------------------------------------------
    // Reset values, sizes and bus encodings
    // ------------------------------------------------------------
    localparam int         KWU_NUM_PINS      = 5;
    localparam logic [7:0] KWU_PIN_RESET     = 8'h00;
    localparam logic       KWU_SENS_RESET    = 1'b0;
    localparam logic       KWU_MASK_RESET    = 1'b0;
    localparam logic [1:0] HTRANS_NONSEQ     = 2'b10;
    localparam logic [1:0] HRESP_OKAY        = 2'b00;
endpackage : kwu_pkg

// ---- kwu_sync.sv ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module kwu_sync #(
    parameter int WIDTH = 5
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;

    // Chain of three flops; first stage feeds only the second
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
        end
        else
        begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // A change counts once stages two and three agree
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            sync_out <= '0;
        else
        begin
            for (int i = 0; i < WIDTH; i++)
            begin
                if (stage2_reg[i] == stage3_reg[i])
                    sync_out[i] <= stage3_reg[i];
            end
        end
    end
endmodule : kwu_sync
`default_nettype wire

// ---- kwu_edge.sv ----
// Polarity correction and edge detection per pin
`timescale 1ns/1ps
`default_nettype none
module kwu_edge #(
    parameter int WIDTH = 5
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic [WIDTH-1:0] pin_level,
    input  wire logic [WIDTH-1:0] pin_polarity_select,
    input  wire logic [WIDTH-1:0] pin_irq_enable,
    output logic      [WIDTH-1:0] asserted,
    output logic      [WIDTH-1:0] edge_seen
);
    logic [WIDTH-1:0] prev_reg;

    // Corrected level: high means asserted for the chosen polarity
    assign asserted = (pin_level ~^ pin_polarity_select) & pin_irq_enable;

    // Previous sample; a newly enabled held pin counts as an edge,
    // which is why software acknowledges after enabling
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            prev_reg <= '0;
        else
            prev_reg <= asserted;
    end

    assign edge_seen = asserted & ~prev_reg;
endmodule : kwu_edge
`default_nettype wire

// ---- kwu_properties.sv ----
// Port checker for the keypad wake unit, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module kwu_properties #(
    parameter int NPINS = 5
) (
    input wire logic             hclk,
    input wire logic             hresetn,
    input wire logic             hsel,
    input wire logic [31:0]      haddr,
    input wire logic [1:0]       htrans,
    input wire logic             hwrite,
    input wire logic             hready,
    input wire logic [31:0]      hrdata,
    input wire logic [NPINS-1:0] keypad_input_pins,
    input wire logic [NPINS-1:0] pin_force_input,
    input wire logic [NPINS-1:0] pull_up_enable,
    input wire logic [NPINS-1:0] pull_down_enable,
    input wire logic             vector_fetch,
    input wire logic             break_state,
    input wire logic             cpu_irq_request,
    input wire logic             pending_flag
);
    logic [NPINS-1:0] act;
    logic [3:0]       quiet_cnt;
    logic             rd_d;
    logic [7:0]       ad_d;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Enabled pins at their asserted level, polarity read back from the pulls
    assign act = (keypad_input_pins & pull_down_enable) | (~keypad_input_pins & pull_up_enable);
    // Quiet cycles; a pull change restarts it, since the swap may fake an edge
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            quiet_cnt <= 4'h0;
        else if (act != '0 || $changed(pull_up_enable) || $changed(pull_down_enable))
            quiet_cnt <= 4'h0;
        else if (quiet_cnt != 4'hA)
            quiet_cnt <= quiet_cnt + 4'h1;
    // Read data phase tracking
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            rd_d <= 1'b0;
            ad_d <= 8'h00;
        end
        else
        begin
            rd_d <= hsel && hready && htrans == 2'b10 && !hwrite;
            ad_d <= haddr[7:0];
        end
    property p_pull_excl; (pull_up_enable & pull_down_enable) == '0; endproperty
    property p_force; pin_force_input == (pull_up_enable | pull_down_enable); endproperty
    property p_no_spur; $rose(pending_flag) |-> quiet_cnt != 4'hA; endproperty
    property p_ack_clear; vector_fetch && !break_state && quiet_cnt == 4'hA |-> ##[1:2] !pending_flag; endproperty
    property p_reset; $rose(hresetn) |-> !pending_flag && !cpu_irq_request; endproperty
    property p_ack_zero; rd_d && ad_d == 8'h00 |-> hrdata[2] == 1'b0; endproperty
    property p_flag_read; rd_d && ad_d == 8'h00 |-> hrdata[3] == $past(pending_flag); endproperty
    property p_irq; cpu_irq_request |-> pending_flag; endproperty
    a_pull_excl: assert property (p_pull_excl) else $error("pull up and pull down together");
    a_force: assert property (p_force) else $error("forced input differs from enables");
    a_no_spur: assert property (p_no_spur) else $error("request without asserted pin");
    a_ack_clear: assert property (p_ack_clear) else $error("vector fetch left request set");
    a_reset: assert property (p_reset) else $error("request survives reset");
    a_ack_zero: assert property (p_ack_zero) else $error("acknowledge bit reads one");
    a_flag_read: assert property (p_flag_read) else $error("flag read differs from latch");
    a_irq: assert property (p_irq) else $error("cpu request without latch");
    c_flag: cover property ($rose(pending_flag));
    c_irq: cover property (cpu_irq_request);
    c_read: cover property (rd_d && ad_d == 8'h00 && hrdata[3]);
endmodule : kwu_properties
bind kwu_keypad_wake_unit kwu_properties #(.NPINS(NPINS)) i_kwu_properties (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hready, .hrdata, .keypad_input_pins, .pin_force_input, .pull_up_enable,
    .pull_down_enable, .vector_fetch, .break_state, .cpu_irq_request, .pending_flag);
`default_nettype wire

// ---- kwu_keypad_model.sv ----
// Keypad switch model: pressed keys drive a line against its pull
`timescale 1ns/1ps
`default_nettype none
module kwu_keypad_model #(
    parameter int NPINS = 5
) (
    input wire logic             hclk,
    input wire logic             hresetn,
    input wire logic [NPINS-1:0] press,
    input wire logic [NPINS-1:0] pull_up_enable,
    input wire logic [NPINS-1:0] pull_down_enable,
    output logic     [NPINS-1:0] keypad_input_pins
);
    logic [NPINS-1:0] float_reg;
    // An unheld line wanders every cycle, so no level is settled by luck
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            float_reg <= '0;
        else
            float_reg <= ~float_reg;
    assign keypad_input_pins = (press & ~pull_up_enable)
        | (~press & (pull_up_enable | (~pull_down_enable & float_reg)));
endmodule : kwu_keypad_model
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the keypad wake unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; $display("wrong value at %0t: %h not %h", $time, a, e); end end
module testbench;
    import kwu_pkg::*;
    localparam logic [7:0] SC = KWU_STATUS_CONTROL_OFS, EN = KWU_PIN_ENABLE_OFS, PO = KWU_PIN_POLARITY_OFS;
    localparam logic [7:0] BK = KWU_BREAK_CTRL_OFS, LV = KWU_PIN_LEVEL_OFS;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'b010;
    logic        vector_fetch = 1'b0, break_state = 1'b0, break_clear_enable_in = 1'b0;
    logic        cpu_irq_request, pending_flag;
    logic [4:0]  keypad_input_pins, port_direction = 5'h18, press = 5'h00;
    logic [4:0]  pin_force_input, pull_up_enable, pull_down_enable;
    int          errors = 0, checked = 0;
    // The single slave closes its own bus
    assign hready = hreadyout;
    // Clock of 50 MHz
    always #10 hclk = ~hclk;
    kwu_keypad_wake_unit #(.NPINS(5)) i_kwu_keypad_wake_unit (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .keypad_input_pins, .port_direction, .pin_force_input,
        .pull_up_enable, .pull_down_enable, .vector_fetch, .break_state, .break_clear_enable_in, .cpu_irq_request,
        .pending_flag);
    kwu_keypad_model i_kwu_keypad_model (.hclk, .hresetn, .press, .pull_up_enable, .pull_down_enable,
        .keypad_input_pins);
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask : cyc
    // One single transfer; both phases wait on hready, with no limit but the watchdog
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        `CHK(q, e)
        `CHK(hresp, HRESP_OKAY[0])
    endtask : rd
    task automatic flag(input logic e);
        `CHK(pending_flag, e)
    endtask : flag
    task end_sim;
        if (errors == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim
    // Watchdog well beyond the roughly 185 cycles of the tests
    initial
    begin
        cyc(5000);
        errors++;
        end_sim();
    end
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial
    begin
        cyc(5);
        hresetn <= 1'b1;
        rd(SC, 32'h0);
        rd(EN, 32'h0);
        rd(PO, 32'h0);
        rd(8'h14, 32'h0);
        wr(SC, 32'h2);
        wr(PO, 32'h3);
        wr(EN, 32'h7);
        cyc(8);
        `CHK(pull_up_enable, 5'h04)
        `CHK(pull_down_enable, 5'h03)
        `CHK(pin_force_input, 5'h07)
        rd(LV, 32'h4);
        wr(SC, 32'h6);
        wr(SC, 32'h0);
        press <= 5'h01;
        cyc(8);
        flag(1'b1);
        `CHK(cpu_irq_request, 1'b1)
        rd(SC, 32'h8);
        wr(SC, 32'h2);
        cyc(2);
        `CHK(cpu_irq_request, 1'b0)
        rd(SC, 32'hA);
        wr(SC, 32'h6);
        cyc(2);
        flag(1'b0);
        press <= 5'h03;
        cyc(8);
        flag(1'b0);
        press <= 5'h08;
        cyc(8);
        flag(1'b0);
        press <= 5'h0C;
        cyc(8);
        flag(1'b1);
        press <= 5'h00;
        cyc(12);
        vector_fetch <= 1'b1;
        cyc(1);
        vector_fetch <= 1'b0;
        cyc(2);
        flag(1'b0);
        // Edge-and-level mode, masked
        wr(SC, 32'h3);
        press <= 5'h01;
        cyc(8);
        rd(SC, 32'hB);
        wr(SC, 32'h7);
        cyc(4);
        flag(1'b1);
        press <= 5'h00;
        cyc(10);
        flag(1'b0);
        press <= 5'h01;
        cyc(8);
        press <= 5'h00;
        cyc(8);
        flag(1'b1);
        break_state <= 1'b1;
        wr(SC, 32'h7);
        cyc(2);
        flag(1'b1);
        wr(BK, 32'h1);
        wr(SC, 32'h7);
        cyc(2);
        flag(1'b0);
        break_state <= 1'b0;
        cyc(4);
        flag(1'b0);
        press <= 5'h01;
        cyc(8);
        hresetn <= 1'b0;
        cyc(2);
        hresetn <= 1'b1;
        cyc(2);
        flag(1'b0);
        rd(SC, 32'h0);
        end_sim();
    end
endmodule : testbench
`default_nettype wire
